// *** logic/pin_mux_pkg.sv ***
// package for the host parallel port pin-function multiplexer
// assumes a 40 mhz clock and an axi4-lite master on the register side
package pin_mux_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [3:0] port_control_off = 4'h0;
  localparam logic [3:0] pin_direction_off = 4'h4;
  localparam logic [3:0] gpio_out_off = 4'h8;
  localparam logic [3:0] pin_status_off = 4'hc;
  localparam int pin_count = 13;
  // host-side signal positions on the upper pins
  localparam int low_addr_pin = 8;
  localparam int rw_rd_pin = 11;
  localparam int ds_wr_pin = 12;
  // ==========================================================
  // port control fields
  localparam int host_function_bit = 0;
  localparam int muxed_bus_bit = 1;
  localparam int dual_strobe_bit = 2;
  localparam int cs_high_bit = 3;
  localparam int as_high_bit = 4;
  localparam int ds_high_bit = 5;
  localparam int stop_mode_bit = 6;
  localparam logic [6:0] port_control_reset = 7'h00;
  localparam logic [pin_count-1:0] pin_direction_reset = 13'h0000;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef struct packed {
    logic stop_mode;
    logic ds_high;
    logic as_high;
    logic cs_high;
    logic dual_strobe;
    logic muxed_bus;
    logic host_function;
  } port_control_s;

  // decoded host-side access, as seen by the device core
  typedef struct packed {
    logic [9:0] addr;
    logic sel;
    logic rd;
    logic wr;
  } host_access_s;
endpackage

// *** logic/pin_sync.sv ***
// two-flop synchroniser for a bundle of asynchronous pin inputs
// assumes inputs come from pins outside the clk domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int width = 13
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pins in, synchronised out
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] meta_reg;

  // ==========================================================
  // first flop read only by the second
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** logic/host_port_pin_function_mux.sv ***
// pin-function multiplexer of the 8-bit host parallel port
// assumes an axi4-lite master; the host bus drives the pins asynchronously
//
// Overview of operation
// - port control register picks host function, bus style, or gpio for the whole port.
// - non-multiplexed host mode: eight pins are bidirectional tri-state data lines.
// - multiplexed host mode: same eight pins carry shared address and data.
// - multiplexed mode: address strobe marks address; polarity is programmable.
// - single-strobe bus: one data strobe qualifies accesses, programmable polarity.
// - dual-strobe bus: dedicated read strobe with programmable polarity.
// - dual-strobe bus: dedicated write strobe with programmable polarity.
// - gpio mode: each pin's direction comes from its direction register bit.
// - stop mode disconnects gpio pins: no driving, no sampling.
// - non-multiplexed mode: chip select qualifies accesses, programmable polarity.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_function_mux
  import pin_mux_pkg::*;
#(
  parameter int pins = pin_mux_pkg::pin_count
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // axi4-lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port pins: bit 0..7 data or gpio_low_pins, 8..12 control or gpio_pin8..12
  input wire logic [pins-1:0] pin_in,
  input wire logic chip_select_in,
  output logic [pins-1:0] pin_out,
  output logic [pins-1:0] pin_oe,
  // device core side
  input wire logic [7:0] host_read_data,
  output logic [7:0] host_write_data,
  output pin_mux_pkg::host_access_s host_access
);
  import pin_mux_pkg::*;

  port_control_s ctrl_reg;
  logic [pins-1:0] pin_direction_reg;
  logic [pins-1:0] gpio_out_reg;
  logic [pins-1:0] pin_sync_q;
  logic [pins:0] sync_all;
  logic cs_sync;
  logic [pins-1:0] gpio_in_reg;
  logic [3:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic [7:0] latched_addr_reg;
  logic cs_act;
  logic as_act;
  logic rd_act;
  logic wr_act;
  logic strobe_act;
  logic host_read;

  // polarity fix: active when pin level equals the programmed active level
  function automatic logic active_level(input logic lvl, input logic high_active);
    active_level = (lvl == high_active);
  endfunction

  // ==========================================================
  // pin synchroniser; host bus is asynchronous to clk
  pin_sync #(.width(pins + 1)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({chip_select_in, pin_in}),
    .sync_out(sync_all)
  );
  assign pin_sync_q = sync_all[pins-1:0];
  assign cs_sync = sync_all[pins];

  // ==========================================================
  // host bus decode
  always_comb
  begin
    cs_act = active_level(cs_sync, ctrl_reg.cs_high);
    as_act = active_level(pin_sync_q[low_addr_pin], ctrl_reg.as_high);
    strobe_act = active_level(pin_sync_q[ds_wr_pin], ctrl_reg.ds_high);
    rd_act = active_level(pin_sync_q[rw_rd_pin], ctrl_reg.ds_high);
    wr_act = strobe_act;
    // multiplexed bus has no chip select pin
    if (ctrl_reg.muxed_bus)
      cs_act = 1'b1;
    if (!ctrl_reg.dual_strobe)
    begin
      // single strobe: the read/write line picks direction, 1 reads
      rd_act = strobe_act && pin_sync_q[rw_rd_pin];
      wr_act = strobe_act && !pin_sync_q[rw_rd_pin];
    end
    host_read = ctrl_reg.host_function && !ctrl_reg.stop_mode && cs_act && rd_act;
  end

  // address latched on the strobe so data can reuse the shared lines
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      latched_addr_reg <= 8'h00;
    else if (ctrl_reg.muxed_bus && as_act)
      latched_addr_reg <= pin_sync_q[7:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      host_access <= '0;
      host_write_data <= 8'h00;
    end
    else
    begin
      host_access.sel <= ctrl_reg.host_function && !ctrl_reg.stop_mode && cs_act;
      host_access.rd <= host_read;
      host_access.wr <= ctrl_reg.host_function && !ctrl_reg.stop_mode && cs_act && wr_act;
      if (ctrl_reg.muxed_bus)
        host_access.addr <= {pin_sync_q[low_addr_pin+2:low_addr_pin+1], latched_addr_reg};
      else
        host_access.addr <= {7'h00, pin_sync_q[low_addr_pin+2:low_addr_pin]};
      host_write_data <= pin_sync_q[7:0];
    end
  end

  // ==========================================================
  // pin drivers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else if (ctrl_reg.stop_mode)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else if (ctrl_reg.host_function)
    begin
      pin_out <= {{(pins-8){1'b0}}, host_read_data};
      pin_oe <= {{(pins-8){1'b0}}, {8{host_read}}};
    end
    else
    begin
      pin_out <= gpio_out_reg;
      pin_oe <= pin_direction_reg;
    end
  end

  // gpio input sampling frozen in stop mode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      gpio_in_reg <= '0;
    else if (!ctrl_reg.stop_mode)
      gpio_in_reg <= pin_sync_q;
  end

  // ==========================================================
  // axi4-lite write channel: address and data taken in either order
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bresp <= resp_okay;
      ctrl_reg <= port_control_reset;
      pin_direction_reg <= pin_direction_reset;
      gpio_out_reg <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_reg && w_have_reg && !s_axi_bvalid)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= resp_okay;
        if (aw_addr_reg == port_control_off)
        begin
          if (w_strb_reg[0])
            ctrl_reg <= port_control_s'(w_data_reg[6:0]);
        end
        else if (aw_addr_reg == pin_direction_off)
        begin
          if (w_strb_reg[0])
            pin_direction_reg[7:0] <= w_data_reg[7:0];
          if (w_strb_reg[1])
            pin_direction_reg[pins-1:8] <= w_data_reg[pins-1:8];
        end
        else if (aw_addr_reg == gpio_out_off)
        begin
          if (w_strb_reg[0])
            gpio_out_reg[7:0] <= w_data_reg[7:0];
          if (w_strb_reg[1])
            gpio_out_reg[pins-1:8] <= w_data_reg[pins-1:8];
        end
        else if (aw_addr_reg != pin_status_off)
          s_axi_bresp <= resp_slverr;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      else if (!s_axi_bvalid && !aw_have_reg && !w_have_reg && !s_axi_awready && !s_axi_wready)
      begin
        // only true on the first edge after reset; keeps ready a plain flop
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= resp_okay;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rresp <= resp_okay;
      if (s_axi_araddr == port_control_off)
        s_axi_rdata <= {25'h0, ctrl_reg};
      else if (s_axi_araddr == pin_direction_off)
        s_axi_rdata <= {{(32-pins){1'b0}}, pin_direction_reg};
      else if (s_axi_araddr == gpio_out_off)
        s_axi_rdata <= {{(32-pins){1'b0}}, gpio_out_reg};
      else if (s_axi_araddr == pin_status_off)
        s_axi_rdata <= {{(32-pins){1'b0}}, gpio_in_reg};
      else
      begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= resp_slverr;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end
endmodule
`default_nettype wire

// *** dv/host_port_pin_function_mux_checker.sv ***
// assertions on the pin mux ports
// assumes it is bound into host_port_pin_function_mux
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_function_mux_checker
  import pin_mux_pkg::*;
#(
  parameter int pins = 13
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register bus
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic [pins-1:0] pin_oe,
  input wire pin_mux_pkg::host_access_s host_access
);
  // ====================================
  // shadow of the control registers
  logic [3:0] aw_reg;
  logic [31:0] w_reg;
  port_control_s ctl_reg;
  logic [pins-1:0] dir_reg;
  logic [2:0] calm_reg;
  logic settled;
  // pins lag a register write by a few edges, so checks wait until it settles
  assign settled = calm_reg == 3'h7 && !s_axi_bvalid;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_reg <= 4'h0;
      w_reg <= 32'h0;
      ctl_reg <= port_control_s'(7'h00);
      dir_reg <= '0;
      calm_reg <= 3'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        w_reg <= s_axi_wdata;
      if (s_axi_bvalid && s_axi_bready)
        calm_reg <= 3'h0;
      else if (calm_reg != 3'h7)
        calm_reg <= calm_reg + 3'h1;
      if (s_axi_bvalid && s_axi_bready && aw_reg == port_control_off)
        ctl_reg <= port_control_s'(w_reg[6:0]);
      if (s_axi_bvalid && s_axi_bready && aw_reg == pin_direction_off)
        dir_reg <= w_reg[pins-1:0];
    end
  end
  // ====================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence host_on;
    settled && ctl_reg.host_function && !ctl_reg.stop_mode;
  endsequence
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_gpio_direction: assert property (
    settled && !ctl_reg.host_function && !ctl_reg.stop_mode |-> pin_oe == dir_reg)
    else $error("gpio enable differs from direction");
  a_stop_release: assert property (
    settled && !ctl_reg.host_function && ctl_reg.stop_mode |-> pin_oe == '0)
    else $error("pin driven in stop mode");
  a_host_ctrl_in: assert property (host_on |-> pin_oe[pins-1:8] == '0)
    else $error("host control pin driven");
  a_read_drive: assert property (host_on and (host_access.sel && host_access.rd) |-> pin_oe[7:0] == 8'hff)
    else $error("read data not driven");
  a_idle_float: assert property (host_on and !(host_access.sel && host_access.rd) |-> pin_oe[7:0] == 8'h00)
    else $error("data pins driven outside read");
  a_reset_float: assert property ($rose(arst_n) |-> pin_oe == '0)
    else $error("pins driven out of reset");
endmodule
bind host_port_pin_function_mux host_port_pin_function_mux_checker #(.pins(pins)) i_chk (
  .clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .pin_oe, .host_access);
`default_nettype wire

// *** dv/host_bus_model.sv ***
// host side of the port: resolves each pin level
// assumes the bench gives the host drive values and enables
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import pin_mux_pkg::*;
(
  // clock
  input wire logic clk,
  // host drive
  input wire logic [pin_count-1:0] drv_val,
  input wire logic [pin_count-1:0] drv_en,
  // device drive
  input wire logic [pin_count-1:0] pin_out,
  input wire logic [pin_count-1:0] pin_oe,
  // wire level
  output logic [pin_count-1:0] pin_lvl
);
  // ====================================
  // resolution
  // no pull on the lines: a floating pin toggles so a stale value never passes
  logic [pin_count-1:0] float_reg = '0;
  always @(posedge clk)
    float_reg <= ~float_reg;
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_val) | (~pin_oe & ~drv_en & float_reg);
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the host port pin mux
// assumes the package, design, model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pin_mux_pkg::*;
  // ====================================
  // signals
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d, v, dir;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [12:0] pin_in, pin_out, pin_oe, drv_val = 13'h0, drv_en = 13'h0;
  logic [7:0] host_read_data = 8'h0, host_write_data;
  logic chip_select_in = 1'h0;
  host_access_s host_access;
  int errors = 0, total_checks = 0;
  host_port_pin_function_mux i_dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pin_in, .chip_select_in, .pin_out, .pin_oe, .host_read_data, .host_write_data, .host_access);
  host_bus_model i_host (.clk, .drv_val, .drv_en, .pin_out, .pin_oe, .pin_lvl(pin_in));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // ====================================
  // tasks
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(inout int n);
    n++;
    if (n > 60)
    begin
      errors++;
      $display("[ERR] %0t bus timeout", $time);
      end_sim();
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      tick(n);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      tick(n);
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask
  // pins pass two sync flops and a decode flop before they show
  task automatic pins(input logic [12:0] val, input logic [12:0] en);
    drv_val <= val;
    drv_en <= en;
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [31:0] ctl_of(input logic m, input logic d, input logic p);
    return {25'h0, 1'h0, p, p, p, d, m, 1'h1};
  endfunction
  // ====================================
  // sequence
  initial
  begin
    v = $urandom(1294);
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    chk(pin_oe, 32'h0);
    axr(port_control_off, rd_d, rd_r);
    chk(rd_d, 32'h0);
    axr(4'h1, rd_d, rd_r);
    chk(rd_r, resp_slverr);
    $display("reset test done");
    repeat (3)
    begin
      dir = $urandom;
      v = $urandom;
      axw(pin_direction_off, dir);
      axw(gpio_out_off, v);
      pins(v[31:19], ~dir[12:0]);
      chk(pin_oe, dir[12:0]);
      chk(pin_out & dir[12:0], v[12:0] & dir[12:0]);
      axr(pin_status_off, rd_d, rd_r);
      chk(rd_d[12:0] & ~dir[12:0], v[31:19] & ~dir[12:0]);
    end
    axw(port_control_off, 32'h40);
    pins(~v[31:19], 13'h1fff);
    chk(pin_oe, 32'h0);
    axr(pin_status_off, v, rd_r);
    chk(v, rd_d);
    $display("gpio test done");
    for (int p = 0; p < 2; p++)
    begin
      v = $urandom;
      host_read_data <= v[23:16];
      chip_select_in <= p[0];
      axw(port_control_off, ctl_of(1'h0, 1'h0, p[0]));
      pins({p[0], 1'h1, 3'h5, 8'h00}, 13'h1f00);
      chk({host_access.sel, host_access.rd, host_access.wr, host_access.addr[2:0]}, {3'h6, 3'h5});
      chk(pin_in[7:0], v[23:16]);
      pins({~p[0], 1'h1, 3'h5, 8'h00}, 13'h1f00);
      chk(pin_oe[7:0], 8'h00);
      chip_select_in <= ~p[0];
      pins({p[0], 1'h1, 3'h5, 8'h00}, 13'h1f00);
      chk({host_access.sel, pin_oe[7:0]}, 9'h000);
      chip_select_in <= p[0];
      pins({p[0], 1'h0, v[18:16], v[15:8]}, 13'h1fff);
      chk({host_access.wr, host_access.addr, host_write_data}, {1'h1, 7'h00, v[18:16], v[15:8]});
    end
    $display("single strobe test done");
    for (int p = 0; p < 2; p++)
    begin
      v = $urandom;
      axw(port_control_off, ctl_of(1'h1, 1'h1, p[0]));
      pins({~p[0], ~p[0], v[17:16], p[0], v[7:0]}, 13'h1fff);
      pins({~p[0], ~p[0], v[17:16], ~p[0], v[15:8]}, 13'h1fff);
      pins({p[0], ~p[0], v[17:16], ~p[0], v[15:8]}, 13'h1fff);
      chk({host_access.wr, host_access.addr}, {1'h1, v[17:16], v[7:0]});
      chk(host_write_data, v[15:8]);
      pins({~p[0], p[0], v[17:16], ~p[0], 8'h00}, 13'h1f00);
      chk({host_access.rd, pin_oe[7:0]}, {1'h1, 8'hff});
      chip_select_in <= p[0];
      axw(port_control_off, ctl_of(1'h0, 1'h1, p[0]));
      pins({~p[0], p[0], v[18:16], 8'h00}, 13'h1f00);
      chk({host_access.rd, host_access.addr, pin_oe[7:0]}, {1'h1, 7'h00, v[18:16], 8'hff});
    end
    $display("dual strobe test done");
    end_sim();
  end
endmodule
`default_nettype wire
